//--- hdl/brf_consts.vh
`ifndef BRF_CONSTS_VH
`define BRF_CONSTS_VH

// Frame address byte and function codes
`define BRF_ADDR_BYTE 8'h00
`define BRF_FC_COIL_RD 8'h01
`define BRF_FC_HOLD_RD 8'h03
`define BRF_FC_COIL_WR 8'h05
`define BRF_FC_WORD_WR 8'h06
`define BRF_FC_MULTI_WR 8'h10
`define BRF_FC_ERR_BIT 8'h80

// Error codes carried after the error function code
`define BRF_ERR_FUNC 8'h01
`define BRF_ERR_LEN 8'h02
`define BRF_ERR_VALUE 8'h03
`define BRF_ERR_CRC 8'h04
`define BRF_ERR_REMOTE 8'h05

// Byte positions within a frame
`define BRF_POS_FC 8'h01
`define BRF_POS_REG 8'h02
`define BRF_POS_NUM 8'h04
`define BRF_POS_CNT 8'h06
`define BRF_POS_DATA 9'h007
`define BRF_POS_RESP 9'h003

// Lengths and limits
`define BRF_MIN_LEN 9'h004
`define BRF_FIX_LEN 9'h008
`define BRF_MULTI_HDR 9'h009
`define BRF_COIL_LEN 9'h005
`define BRF_ERR_LEN_B 9'h003
`define BRF_COIL_BYTES 8'h02
`define BRF_HOLD_MAX 16'h007D
`define BRF_MULTI_MAX 16'h007B

// Coil words and checksum
`define BRF_COIL_TRUE 16'hFF00
`define BRF_COIL_FALSE 16'h0000
`define BRF_CRC_INIT 16'hFFFF
`define BRF_CRC_POLY 16'hA001
`define BRF_CRC_GOOD 16'h0000

`endif

//--- hdl/brf_crc16.v
`timescale 1ns/1ps
`include "brf_consts.vh"

module brf_crc16 (
    // Running checksum and next byte
    input wire [15:0] crc_in,
    input wire [7:0] data_in,
    // Checksum after the byte
    output wire [15:0] crc_out
);

    wire [15:0] stage [0:8];

    // Reflected polynomial, one shift per bit, low bit first
    assign stage[0] = crc_in ^ {8'h00, data_in};
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            assign stage[i + 1] = stage[i][0] ?
                ((stage[i] >> 1) ^ `BRF_CRC_POLY) : (stage[i] >> 1);
        end
    endgenerate
    assign crc_out = stage[8];

endmodule

//--- hdl/brf_fifo.v
`timescale 1ns/1ps

module brf_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Fill side
    input wire in_valid,
    output reg in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output reg out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    localparam [AW:0] FULL = DEPTH[AW:0];

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire do_wr = in_valid && in_ready;
    wire do_rd = out_valid && out_ready;
    wire [AW:0] count_next = count_reg + {{AW{1'b0}}, do_wr}
        - {{AW{1'b0}}, do_rd};

    // Storage has no reset; pointers, count and both flags get defined values
    always @(posedge ref_clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    assign out_data = mem[rd_ptr_reg];

    // Flags follow the next count so both sides see honest state
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
            in_ready <= (count_next != FULL);
            out_valid <= (count_next != {(AW+1){1'b0}});
        end
    end

endmodule

//--- hdl/brf_frame_handler.v
`timescale 1ns/1ps
`include "brf_consts.vh"

// Notes on behaviour
// R1: first frame byte is address, always 0
// R2: nonzero first byte routes frame to text
// R3: second byte is the function code
// R4: only codes 01, 03, 05, 06, 10 accepted
// R5: coil read returns FF00 or 0000 word
// R6: holding read of n words returns 2n bytes
// R7: coil write word is one boolean
// R8: single write is eight bytes fixed
// R9: multi write byte count twice register count
// R10: host keeps multi write inside one block
// R11: fields high byte first, checksum low first
// R12: reads answer with data, writes echo frame
// R13: registers are whole 16-bit words
// R14: host write names register and one value
// R15: minimal write expects checksum at byte 7
// R16: wrong frame length answers as checksum error; frames under 4 bytes are dropped with no answer
// R17: write length checked against register maximum
// R18: error answer is code plus 80, error byte
// R19: checksum is serial register protocol CRC16
// R20: writes refused unless under remote control
// R21: checksum checked before acting on frame
module brf_frame_handler (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Incoming byte stream
    input wire [7:0] rx_data,
    input wire rx_valid,
    input wire rx_last,
    output reg rx_ready,
    // Outgoing byte stream
    output wire [7:0] tx_data,
    output wire tx_valid,
    output wire tx_last,
    input wire tx_ready,
    // Text command path
    output reg [7:0] txt_data,
    output reg txt_valid,
    output reg txt_last,
    // Register access
    output reg [15:0] reg_addr,
    output reg [15:0] reg_wr_data,
    output reg reg_wr,
    output reg reg_rd,
    input wire [15:0] reg_rd_data,
    input wire [7:0] reg_max_words,
    // Coil access
    output reg coil_wr,
    output reg coil_value,
    output reg coil_rd,
    input wire coil_rd_bit,
    // Control location
    input wire remote_ctl
);
    localparam S_RX = 4'h0, S_TEXT = 4'h1, S_CHECK = 4'h2, S_WRITE = 4'h3;
    localparam S_WAIT = 4'h4, S_HI = 4'h5, S_LO = 4'h6, S_EMIT = 4'h7;
    localparam S_CRC_LO = 4'h8, S_CRC_HI = 4'h9;
    reg [7:0] mem [0:255];
    reg [3:0] state_reg;
    reg [8:0] len_reg, body_len_reg, idx_reg, ptr_reg;
    reg ovf_reg, add_crc_reg;
    reg [15:0] rx_crc_reg, tx_crc_reg, word_reg;
    reg [7:0] resp_fc_reg, resp_b2_reg, cnt_reg;
    wire [15:0] rx_crc_next, tx_crc_next;
    wire fifo_in_ready;
    reg [7:0] emit_byte, chk_err, mem_wa, mem_wd;
    reg emit_last, mem_we;
    wire emit_valid = (state_reg == S_EMIT) || (state_reg == S_CRC_LO)
        || (state_reg == S_CRC_HI);
    wire push = emit_valid && fifo_in_ready;
    wire rx_take = rx_valid && rx_ready;
    // Fields of the held frame
    wire [7:0] fc = mem[`BRF_POS_FC]; // R3
    wire [15:0] num = {mem[`BRF_POS_NUM], mem[`BRF_POS_NUM + 8'h01]};
    wire [7:0] byte_cnt = mem[`BRF_POS_CNT];
    wire [15:0] wr_word = {mem[ptr_reg[7:0]], mem[ptr_reg[7:0] + 8'h01]};
    wire [8:0] multi_len = `BRF_MULTI_HDR + {1'b0, byte_cnt}; // R9
    wire is_write = (fc == `BRF_FC_COIL_WR) || (fc == `BRF_FC_WORD_WR)
        || (fc == `BRF_FC_MULTI_WR);
    wire known = is_write || (fc == `BRF_FC_COIL_RD)
        || (fc == `BRF_FC_HOLD_RD); // R4
    brf_crc16 u_rx_crc (
        .crc_in(rx_crc_reg),
        .data_in(rx_data),
        .crc_out(rx_crc_next)
    );
    brf_crc16 u_tx_crc (
        .crc_in(tx_crc_reg),
        .data_in(emit_byte),
        .crc_out(tx_crc_next)
    );
    // Answer bytes wait here so a slow link stalls the emitter
    brf_fifo #(.WIDTH(9), .DEPTH(8), .AW(3)) u_tx_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .in_valid(emit_valid),
        .in_ready(fifo_in_ready),
        .in_data({emit_last, emit_byte}),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data({tx_last, tx_data})
    );
    // Frame check; checksum first, then layout, then permission
    always @* begin
        chk_err = 8'h00;
        if (ovf_reg || rx_crc_reg != `BRF_CRC_GOOD) begin
            chk_err = `BRF_ERR_CRC; // R21
        end else if (!known) begin
            chk_err = `BRF_ERR_FUNC; // R4
        end else if ((fc == `BRF_FC_MULTI_WR) ? len_reg != multi_len
                : len_reg != `BRF_FIX_LEN) begin // R15
            chk_err = `BRF_ERR_CRC; // R16
        end else if (fc == `BRF_FC_COIL_RD && num != 16'h0001) begin
            chk_err = `BRF_ERR_VALUE;
        end else if (fc == `BRF_FC_HOLD_RD && (num == 16'h0000
                || num > `BRF_HOLD_MAX)) begin
            chk_err = `BRF_ERR_VALUE;
        end else if (fc == `BRF_FC_COIL_WR && num != `BRF_COIL_TRUE
                && num != `BRF_COIL_FALSE) begin
            chk_err = `BRF_ERR_VALUE; // R7
        end else if (fc == `BRF_FC_MULTI_WR && (num == 16'h0000
                || num > `BRF_MULTI_MAX
                || {8'h00, byte_cnt} != {num[14:0], 1'b0})) begin
            chk_err = `BRF_ERR_VALUE; // R9
        end else if ((fc == `BRF_FC_MULTI_WR) ? num > {8'h00, reg_max_words}
                : (fc == `BRF_FC_WORD_WR && reg_max_words == 8'h00)) begin
            chk_err = `BRF_ERR_LEN; // R17
        end else if (is_write && !remote_ctl) begin
            chk_err = `BRF_ERR_REMOTE; // R20
        end
    end
    // Answer byte select; address byte is constant, the next two header bytes come from registers
    always @* begin
        emit_last = 1'b0;
        if (state_reg == S_CRC_LO) begin
            emit_byte = tx_crc_reg[7:0]; // R11
        end else if (state_reg == S_CRC_HI) begin
            emit_byte = tx_crc_reg[15:8];
            emit_last = 1'b1;
        end else begin
            if (idx_reg == 9'h000) begin
                emit_byte = `BRF_ADDR_BYTE; // R1
            end else if (idx_reg == 9'h001) begin
                emit_byte = resp_fc_reg;
            end else if (idx_reg == 9'h002) begin
                emit_byte = resp_b2_reg;
            end else begin
                emit_byte = mem[idx_reg[7:0]];
            end
            emit_last = !add_crc_reg
                && (idx_reg == body_len_reg - 9'h001);
        end
    end
    // One write port: frame bytes while receiving, read data later
    always @* begin
        mem_we = 1'b0;
        mem_wa = len_reg[7:0];
        mem_wd = rx_data;
        if (state_reg == S_RX && rx_take && !len_reg[8]) begin
            mem_we = 1'b1;
        end else if (state_reg == S_HI) begin
            mem_we = 1'b1;
            mem_wa = ptr_reg[7:0];
            mem_wd = (resp_fc_reg == `BRF_FC_COIL_RD) ?
                (coil_rd_bit ? 8'hFF : 8'h00) : reg_rd_data[15:8]; // R5
        end else if (state_reg == S_LO) begin
            mem_we = 1'b1;
            mem_wa = ptr_reg[7:0] + 8'h01;
            mem_wd = word_reg[7:0]; // R13
        end
    end
    always @(posedge ref_clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end
    // Main sequencer
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= S_RX;
            len_reg <= 9'h000;
            ovf_reg <= 1'b0;
            rx_crc_reg <= `BRF_CRC_INIT;
            tx_crc_reg <= `BRF_CRC_INIT;
            resp_fc_reg <= 8'h00;
            resp_b2_reg <= 8'h00;
            body_len_reg <= 9'h000;
            idx_reg <= 9'h000;
            ptr_reg <= 9'h000;
            cnt_reg <= 8'h00;
            word_reg <= 16'h0000;
            add_crc_reg <= 1'b0;
            rx_ready <= 1'b1;
            txt_data <= 8'h00;
            txt_valid <= 1'b0;
            txt_last <= 1'b0;
            reg_addr <= 16'h0000;
            reg_wr_data <= 16'h0000;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            coil_wr <= 1'b0;
            coil_value <= 1'b0;
            coil_rd <= 1'b0;
        end else begin
            txt_valid <= 1'b0;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            coil_wr <= 1'b0;
            coil_rd <= 1'b0;
            case (state_reg)
            S_RX: begin
                if (rx_take && len_reg == 9'h000
                        && rx_data != `BRF_ADDR_BYTE) begin
                    // Text language never starts with a zero byte
                    txt_data <= rx_data; // R2
                    txt_valid <= 1'b1;
                    txt_last <= rx_last;
                    if (!rx_last) begin
                        state_reg <= S_TEXT;
                    end
                end else if (rx_take) begin
                    rx_crc_reg <= rx_crc_next; // R19
                    if (len_reg[8]) begin
                        ovf_reg <= 1'b1;
                    end else begin
                        len_reg <= len_reg + 9'h001;
                    end
                    if (len_reg == 9'h003) begin
                        reg_addr <= {mem[`BRF_POS_REG], rx_data};
                    end
                    if (rx_last) begin
                        rx_ready <= 1'b0;
                        state_reg <= S_CHECK;
                    end
                end
            end
            S_TEXT: begin
                if (rx_take) begin
                    txt_data <= rx_data; // R2
                    txt_valid <= 1'b1;
                    txt_last <= rx_last;
                    if (rx_last) begin
                        state_reg <= S_RX;
                    end
                end
            end
            S_CHECK: begin
                tx_crc_reg <= `BRF_CRC_INIT; // Fresh seed per answer
                idx_reg <= 9'h000;
                add_crc_reg <= 1'b1;
                resp_fc_reg <= fc;
                if (len_reg < `BRF_MIN_LEN) begin
                    // Too short to name a function; dropped silently
                    len_reg <= 9'h000;
                    rx_crc_reg <= `BRF_CRC_INIT;
                    ovf_reg <= 1'b0;
                    rx_ready <= 1'b1;
                    state_reg <= S_RX;
                end else if (chk_err != 8'h00) begin
                    resp_fc_reg <= fc | `BRF_FC_ERR_BIT; // R18
                    resp_b2_reg <= chk_err;
                    body_len_reg <= `BRF_ERR_LEN_B;
                    state_reg <= S_EMIT;
                end else if (fc == `BRF_FC_COIL_RD) begin
                    coil_rd <= 1'b1;
                    cnt_reg <= 8'h01;
                    ptr_reg <= `BRF_POS_RESP;
                    resp_b2_reg <= `BRF_COIL_BYTES; // R5
                    body_len_reg <= `BRF_COIL_LEN;
                    state_reg <= S_WAIT;
                end else if (fc == `BRF_FC_HOLD_RD) begin
                    reg_rd <= 1'b1;
                    cnt_reg <= num[7:0];
                    ptr_reg <= `BRF_POS_RESP;
                    resp_b2_reg <= {num[6:0], 1'b0}; // R6
                    body_len_reg <= `BRF_POS_RESP + {num[7:0], 1'b0};
                    state_reg <= S_WAIT;
                end else begin
                    // Writes answer by echoing the frame as received
                    resp_b2_reg <= mem[`BRF_POS_REG]; // R12
                    body_len_reg <= len_reg;
                    add_crc_reg <= 1'b0;
                    if (fc == `BRF_FC_COIL_WR) begin
                        coil_wr <= 1'b1;
                        coil_value <= (num == `BRF_COIL_TRUE); // R7
                        state_reg <= S_EMIT;
                    end else if (fc == `BRF_FC_WORD_WR) begin
                        reg_wr <= 1'b1;
                        reg_wr_data <= num; // R8
                        state_reg <= S_EMIT;
                    end else begin
                        cnt_reg <= num[7:0];
                        ptr_reg <= `BRF_POS_DATA;
                        state_reg <= S_WRITE;
                    end
                end
            end
            S_WRITE: begin
                // One word per cycle, address steps after the first
                reg_wr <= 1'b1; // R9
                reg_wr_data <= wr_word; // R11
                if (reg_wr) begin
                    reg_addr <= reg_addr + 16'h0001;
                end
                ptr_reg <= ptr_reg + 9'h002;
                cnt_reg <= cnt_reg - 8'h01;
                if (cnt_reg == 8'h01) begin
                    state_reg <= S_EMIT;
                end
            end
            S_WAIT: begin
                state_reg <= S_HI;
            end
            S_HI: begin
                word_reg <= (resp_fc_reg == `BRF_FC_COIL_RD) ?
                    (coil_rd_bit ? `BRF_COIL_TRUE : `BRF_COIL_FALSE)
                    : reg_rd_data; // R5
                state_reg <= S_LO;
            end
            S_LO: begin
                ptr_reg <= ptr_reg + 9'h002;
                cnt_reg <= cnt_reg - 8'h01;
                if (cnt_reg == 8'h01) begin
                    state_reg <= S_EMIT;
                end else begin
                    reg_rd <= 1'b1;
                    reg_addr <= reg_addr + 16'h0001;
                    state_reg <= S_WAIT;
                end
            end
            S_EMIT: begin
                if (push) begin
                    tx_crc_reg <= tx_crc_next;
                    idx_reg <= idx_reg + 9'h001;
                    if (idx_reg == body_len_reg - 9'h001) begin
                        state_reg <= add_crc_reg ? S_CRC_LO : S_RX;
                        rx_ready <= !add_crc_reg;
                        len_reg <= 9'h000;
                        ovf_reg <= 1'b0;
                        rx_crc_reg <= `BRF_CRC_INIT;
                    end
                end
            end
            S_CRC_LO: begin
                if (push) begin
                    state_reg <= S_CRC_HI;
                end
            end
            S_CRC_HI: begin
                if (push) begin
                    rx_ready <= 1'b1;
                    state_reg <= S_RX;
                end
            end
            default: begin
                state_reg <= S_RX;
            end
            endcase
        end
    end
endmodule

//--- verif/brf_frame_handler_tb_top.sv
`timescale 1ns/1ps
module brf_frame_handler_tb_top;
    logic ref_clk = 1'b0, rst_b = 1'b0, remote_ctl = 1'b1;
    logic [15:0] rd_data_reg = 16'h0000;
    logic rd_bit_reg = 1'b0;
    wire [7:0] rx_data, tx_data, txt_data, reg_max_words;
    wire rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
    wire txt_valid, txt_last, reg_wr, reg_rd, coil_wr, coil_value, coil_rd;
    wire [15:0] reg_addr, reg_wr_data;
    int n_mismatch = 0, compares = 0;
    logic [31:0] exp_tx[$], exp_wr[$], exp_txt[$];
    logic [7:0] fr[$], ex[$];
    logic [7:0] ecode[9] = '{8'h01, 8'h03, 8'h02, 8'h02, 8'h04, 8'h04,
        8'h05, 8'h03, 8'h03};
    logic [15:0] a, w;

    always #4 ref_clk = ~ref_clk;
    brf_frame_handler dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last),
        .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_ready(tx_ready), .txt_data(txt_data),
        .txt_valid(txt_valid), .txt_last(txt_last), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rd_data(rd_data_reg), .reg_max_words(reg_max_words),
        .coil_wr(coil_wr), .coil_value(coil_value), .coil_rd(coil_rd),
        .coil_rd_bit(rd_bit_reg), .remote_ctl(remote_ctl));
    brf_host_model host (.ref_clk(ref_clk), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready),
        .tx_ready(tx_ready));
    // Register stand-in; data ready one edge after the fetch pulse
    always @(posedge ref_clk) begin
        if (reg_rd || coil_rd) begin
            rd_data_reg <= reg_addr ^ 16'h5A3C;
            rd_bit_reg <= reg_addr[0];
        end
    end
    // Addresses with bit 8 set are read only, the rest hold four words
    assign reg_max_words = reg_addr[8] ? 8'h00 : 8'h04;

    task check(input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] nxt(input int k);
        if (k == 0 && exp_tx.size())
            return exp_tx.pop_front();
        if (k == 1 && exp_wr.size())
            return exp_wr.pop_front();
        if (k == 2 && exp_txt.size())
            return exp_txt.pop_front();
        return 32'hFFFF_FFFF;
    endfunction
    // Oldest note taken whenever the design shows a result
    always @(posedge ref_clk) begin
        if (rst_b && tx_valid && tx_ready)
            check({23'h0, tx_last, tx_data}, nxt(0));
        if (rst_b && reg_wr)
            check({reg_addr, reg_wr_data}, nxt(1));
        if (rst_b && coil_wr)
            check({reg_addr, 15'h0, coil_value}, nxt(1));
        if (rst_b && txt_valid)
            check({23'h0, txt_last, txt_data}, nxt(2));
    end
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++)
                c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    task seal(inout logic [7:0] q[$]);
        logic [15:0] c;
        c = crc16(q);
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
    endtask
    task note(input logic [7:0] q[$], input bit txt);
        foreach (q[i]) begin
            if (txt)
                exp_txt.push_back({23'h0, i == q.size() - 1, q[i]});
            else
                exp_tx.push_back({23'h0, i == q.size() - 1, q[i]});
        end
    endtask
    task hdr(input logic [7:0] fc, input logic [15:0] ad, wd);
        fr = {8'h00, fc, ad[15:8], ad[7:0], wd[15:8], wd[7:0]};
    endtask
    task multi(input logic [15:0] ad, input logic [7:0] n, cnt, bit wr);
        logic [15:0] v;
        hdr(8'h10, ad, {8'h00, n});
        fr.push_back(cnt);
        for (int k = 0; k < n; k++) begin
            v = $urandom;
            fr.push_back(v[15:8]);
            fr.push_back(v[7:0]);
            if (wr)
                exp_wr.push_back({16'(ad + k), v});
        end
    endtask
    // Hold ends after 40 cycles, then all notes must be used up
    task settle;
        repeat (40) @(posedge ref_clk);
        #1 host.hold = 1'b0;
        for (int k = 0; k < 600 && exp_tx.size() + exp_wr.size() +
            exp_txt.size() != 0; k++) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
        #1 check(exp_tx.size() + exp_wr.size() + exp_txt.size(), 0);
    endtask
    task run(input bit echo, bad);
        seal(fr);
        if (bad)
            fr[fr.size() - 1] = ~fr[fr.size() - 1];
        if (echo)
            ex = fr;
        else
            seal(ex);
        note(ex, 1'b0);
        host.send(fr);
        settle;
    endtask
    task summarize;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #400000 n_mismatch++;
        summarize;
    end
    initial begin
        void'($urandom(44));
        repeat (20) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        // Holding reads; the last one fills the stalled FIFO and stalls the emitter
        for (int n = 1; n <= 3; n++) begin
            a = $urandom;
            hdr(8'h03, a, 16'(n));
            ex = {8'h00, 8'h03, 8'(2 * n)};
            for (int k = 0; k < n; k++) begin
                w = 16'(a + k) ^ 16'h5A3C;
                ex.push_back(w[15:8]);
                ex.push_back(w[7:0]);
            end
            host.hold = (n == 3);
            run(1'b0, 1'b0);
        end
        for (int c = 0; c < 2; c++) begin
            a = ($urandom & 16'hFFFE) | 16'(c);
            hdr(8'h01, a, 16'h0001);
            ex = {8'h00, 8'h01, 8'h02, c ? 8'hFF : 8'h00, 8'h00};
            run(1'b0, 1'b0);
            hdr(8'h05, a & 16'h00FF, c ? 16'hFF00 : 16'h0000);
            exp_wr.push_back({a & 16'h00FF, 15'h0, 1'(c)});
            run(1'b1, 1'b0);
        end
        a = $urandom & 16'h00FF;
        w = $urandom;
        hdr(8'h06, a, w);
        exp_wr.push_back({a, w});
        run(1'b1, 1'b0);
        multi(a & 16'h00F0, 8'h04, 8'h08, 1'b1);
        run(1'b1, 1'b0);
        // Refused requests get an error frame
        for (int e = 0; e < 9; e++) begin
            a = $urandom & 16'h00FF;
            w = $urandom;
            remote_ctl = (e != 6);
            case (e)
                0: hdr(8'h07, a, w);
                1: hdr(8'h05, a, 16'h1234);
                2: multi(a, 8'h05, 8'h0A, 1'b0);
                3: hdr(8'h06, 16'h0100, w);
                5: begin
                    hdr(8'h06, a, w);
                    fr.push_back(8'h00);
                end
                7: hdr(8'h03, a, 16'h0000);
                8: multi(a, 8'h00, 8'h00, 1'b0);
                default: hdr(8'h06, a, w);
            endcase
            ex = {8'h00, fr[1] | 8'h80, ecode[e]};
            run(1'b0, e == 4);
        end
        remote_ctl = 1'b1;
        fr = {8'h2A, 8'h3F, 8'h0A};
        note(fr, 1'b1);
        host.send(fr);
        settle;
        fr = {8'h00, 8'h03, 8'h00};
        host.send(fr);
        settle;
        summarize;
    end
endmodule

bind brf_frame_handler brf_monitor mon (.ref_clk(ref_clk), .rst_b(rst_b),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready), .txt_data(txt_data), .txt_valid(txt_valid),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .coil_wr(coil_wr), .remote_ctl(remote_ctl));

//--- verif/brf_host_model.sv
`timescale 1ns/1ps
module brf_host_model (
    // Clock
    input wire ref_clk,
    // Request stream
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_last,
    input wire rx_ready,
    // Answer stream
    output logic tx_ready
);
    bit hold = 1'b0;
    initial begin
        rx_data = 8'hA5;
        rx_valid = 1'b0;
        rx_last = 1'b0;
        tx_ready = 1'b0;
    end
    // Random sink stalls; hold lets the bench fill the FIFO
    always @(posedge ref_clk) begin
        #1 tx_ready = !hold && ($urandom % 4 != 0);
    end
    // Each byte held until taken; idle data inverted, never stale
    task send(input logic [7:0] f[$]);
        foreach (f[i]) begin
            rx_data = f[i];
            rx_valid = 1'b1;
            rx_last = (i == f.size() - 1);
            @(posedge ref_clk);
            while (!rx_ready) @(posedge ref_clk);
            #1;
        end
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_data = ~rx_data;
    endtask
endmodule

//--- verif/brf_monitor.sv
`timescale 1ns/1ps
module brf_monitor (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Byte streams
    input wire [7:0] rx_data,
    input wire rx_valid,
    input wire rx_ready,
    input wire [7:0] tx_data,
    input wire tx_valid,
    input wire tx_last,
    input wire tx_ready,
    input wire [7:0] txt_data,
    input wire txt_valid,
    // Register side
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire coil_wr,
    input wire remote_ctl
);
    reg at_start_reg;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // Marks the next answer byte as a frame start
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            at_start_reg <= 1'b1;
        end else if (tx_valid && tx_ready) begin
            at_start_reg <= tx_last;
        end
    end
    AST_TXT_SRC: assert property (txt_valid |-> $past(rx_valid && rx_ready))
        else $error("text byte without a taken input byte");
    AST_TXT_DATA: assert property (txt_valid |-> txt_data == $past(rx_data))
        else $error("text byte differs from input byte");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("answer byte changed while stalled");
    AST_FIRST_BYTE: assert property (tx_valid && at_start_reg |->
        tx_data == 8'h00)
        else $error("answer does not start with zero");
    AST_ACT_CHECKED: assert property ((reg_rd || reg_wr || coil_wr) |->
        !rx_ready)
        else $error("access while frame still arriving");
    AST_WR_REMOTE: assert property ((reg_wr || coil_wr) |-> remote_ctl)
        else $error("write outside remote control");
    AST_MULTI_STEP: assert property (reg_wr && $past(reg_wr) |->
        reg_addr == $past(reg_addr) + 16'h0001)
        else $error("multi write address did not step");
    AST_RD_PULSE: assert property (reg_rd |=> !reg_rd)
        else $error("fetch pulse longer than one cycle");
    // Main scenarios
    cover property (reg_wr ##1 reg_wr);
    cover property (txt_valid);
    cover property (coil_wr);
    cover property (tx_valid && !tx_ready [*3]);
endmodule
